// File: adc_trim_pkg.sv
`default_nettype none

package adc_trim_pkg;

    // Register port
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Register offsets, one byte each
    localparam logic [11:0] OFF_TIMING_B_SINGLE_BG = 12'h085;
    localparam logic [11:0] OFF_TIMING_A_DUAL = 12'h086;
    localparam logic [11:0] OFF_TIMING_C_FOR_A_DUAL = 12'h087;
    localparam logic [11:0] OFF_TIMING_C_FOR_B_DUAL = 12'h088;
    localparam logic [11:0] OFF_TIMING_B_DUAL = 12'h089;
    localparam logic [11:0] OFF_OFFSET_A_LO = 12'h08a;
    localparam logic [11:0] OFF_OFFSET_A_HI = 12'h08b;

    // Timing-adjust bank indices, index = offset - first offset
    localparam int TADJ_COUNT = 5;
    localparam int IDX_B_SINGLE_BG = 0;
    localparam int IDX_A_DUAL = 1;
    localparam int IDX_C_FOR_A_DUAL = 2;
    localparam int IDX_C_FOR_B_DUAL = 3;
    localparam int IDX_B_DUAL = 4;

    // Offset-adjust field layout
    localparam int OADJ_W = 16;
    localparam int OADJ_VALUE_W = 12;
    localparam int OADJ_RSVD_LSB = 12;

    // Values after reset, before the factory trim is loaded
    localparam logic [7:0] TADJ_RESET = 8'h00;
    localparam logic [15:0] OADJ_RESET = 16'h0000;
    localparam logic [3:0] OADJ_RSVD_RESET = 4'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Converter cores
    localparam int CORE_COUNT = 3;
    localparam int CORE_A = 0;
    localparam int CORE_B = 1;
    localparam int CORE_C = 2;

    // Factory trim load sequence
    typedef enum logic [1:0] {FUSE_WAIT, FUSE_LOAD, FUSE_DONE} fuse_state_type;
    localparam fuse_state_type FUSE_RESET_STATE = FUSE_WAIT;

endpackage

`default_nettype wire

// File: trim_fuse_loader.sv
`default_nettype none

module trim_fuse_loader (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Load control
    output logic o_load,
    output logic o_done
);

    typedef struct packed {
        adc_trim_pkg::fuse_state_type state;
    } loader_state_type;

    loader_state_type state_r;
    loader_state_type state_nxt;

    // Factory values are copied once, on the second edge after reset release
    always_comb begin
        state_nxt = state_r;
        case (state_r.state)
            adc_trim_pkg::FUSE_WAIT: begin
                state_nxt.state = adc_trim_pkg::FUSE_LOAD;
            end
            adc_trim_pkg::FUSE_LOAD: begin
                state_nxt.state = adc_trim_pkg::FUSE_DONE;
            end
            adc_trim_pkg::FUSE_DONE: begin
                state_nxt.state = adc_trim_pkg::FUSE_DONE;
            end
            default: begin
                state_nxt.state = adc_trim_pkg::FUSE_RESET_STATE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= '{state: adc_trim_pkg::FUSE_RESET_STATE};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_load = (state_r.state == adc_trim_pkg::FUSE_LOAD);
    assign o_done = (state_r.state == adc_trim_pkg::FUSE_DONE);

    a_load_once: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_load |=> !o_load && o_done [*2])
        else $error("factory load not a single pulse");

endmodule

`default_nettype wire

// File: timing_adjust_select.sv
`default_nettype none

module timing_adjust_select #(
    parameter int CORES = adc_trim_pkg::CORE_COUNT
) (
    // Bank contents
    input wire logic [adc_trim_pkg::TADJ_COUNT-1:0][7:0] i_tadj,
    // Operating state
    input wire logic i_dual_mode,
    input wire logic i_bg_phase,
    // Per-core result
    output logic [CORES-1:0][7:0] o_timing,
    output logic [CORES-1:0] o_valid
);

    for (genvar c = 0; c < CORES; c++) begin : g_core
        logic [7:0] pick;
        logic use_bank;
        always_comb begin
            pick = adc_trim_pkg::TADJ_RESET;
            use_bank = 1'b0;
            if (i_dual_mode) begin
                use_bank = 1'b1;
                if (c == adc_trim_pkg::CORE_A) begin
                    pick = i_tadj[adc_trim_pkg::IDX_A_DUAL];
                end else if (c == adc_trim_pkg::CORE_B) begin
                    pick = i_tadj[adc_trim_pkg::IDX_B_DUAL];
                end else if (i_bg_phase) begin
                    pick = i_tadj[adc_trim_pkg::IDX_C_FOR_B_DUAL];
                end else begin
                    pick = i_tadj[adc_trim_pkg::IDX_C_FOR_A_DUAL];
                end
            end else if (c == adc_trim_pkg::CORE_B && !i_bg_phase) begin
                // Core B, single-channel, background phase 0
                use_bank = 1'b1;
                pick = i_tadj[adc_trim_pkg::IDX_B_SINGLE_BG];
            end
        end
        assign o_timing[c] = pick;
        assign o_valid[c] = use_bank;
    end

endmodule

`default_nettype wire

// File: adc_core_trim_register_bank.sv
// Decided for this implementation: the strobed register port.
`default_nettype none

module adc_core_trim_register_bank (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Register port
    input wire logic [adc_trim_pkg::ADDR_W-1:0] i_addr,
    input wire logic [adc_trim_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [adc_trim_pkg::DATA_W-1:0] o_rdata,
    // Factory trim values
    input wire logic [7:0] i_factory_timing_b_single_bg,
    input wire logic [7:0] i_factory_timing_a_dual,
    input wire logic [7:0] i_factory_timing_c_for_a_dual,
    input wire logic [7:0] i_factory_timing_c_for_b_dual,
    input wire logic [7:0] i_factory_timing_b_dual,
    input wire logic [11:0] i_factory_offset_a_input_a,
    // Operating state
    input wire logic i_dual_channel_mode,
    input wire logic i_background_phase,
    input wire logic i_core_a_samples_input_a,
    // Calibration state
    input wire logic i_foreground_calibration_busy,
    input wire logic i_foreground_calibration_done,
    input wire logic i_offset_calibration_enable,
    input wire logic i_background_calibration_enable,
    input wire logic i_background_offset_calibration_enable,
    input wire logic i_calibration_stopped_flag,
    // Core controls
    output logic [7:0] o_core_a_timing,
    output logic [7:0] o_core_b_timing,
    output logic [7:0] o_core_c_timing,
    output logic [2:0] o_core_timing_valid,
    output logic [11:0] o_core_a_offset,
    output logic o_core_a_offset_apply,
    // Status
    output logic o_trim_loaded,
    output logic o_offset_write_hazard,
    output logic o_offset_read_hazard
);

    localparam int CORES = adc_trim_pkg::CORE_COUNT;
    localparam int TADJ_N = adc_trim_pkg::TADJ_COUNT;

    typedef struct packed {
        logic [TADJ_N-1:0][7:0] tadj;
        logic [adc_trim_pkg::OADJ_W-1:0] oadj;
        logic [7:0] rdata;
        logic [CORES-1:0][7:0] core_timing;
        logic [CORES-1:0] core_valid;
        logic [11:0] core_a_offset;
        logic core_a_apply;
        logic loaded;
        logic wr_hazard;
        logic rd_hazard;
    } trim_state_type;

    trim_state_type state_r;
    trim_state_type state_nxt;

    logic fuse_load;
    logic fuse_done;
    logic [TADJ_N-1:0][7:0] factory_tadj;
    logic [CORES-1:0][7:0] sel_timing;
    logic [CORES-1:0] sel_valid;
    logic hit_oadj;

    trim_fuse_loader u_loader (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .o_load(fuse_load),
        .o_done(fuse_done)
    );

    timing_adjust_select #(
        .CORES(CORES)
    ) u_select (
        .i_tadj(state_r.tadj),
        .i_dual_mode(i_dual_channel_mode),
        .i_bg_phase(i_background_phase),
        .o_timing(sel_timing),
        .o_valid(sel_valid)
    );

    assign factory_tadj[adc_trim_pkg::IDX_B_SINGLE_BG] = i_factory_timing_b_single_bg;
    assign factory_tadj[adc_trim_pkg::IDX_A_DUAL] = i_factory_timing_a_dual;
    assign factory_tadj[adc_trim_pkg::IDX_C_FOR_A_DUAL] = i_factory_timing_c_for_a_dual;
    assign factory_tadj[adc_trim_pkg::IDX_C_FOR_B_DUAL] = i_factory_timing_c_for_b_dual;
    assign factory_tadj[adc_trim_pkg::IDX_B_DUAL] = i_factory_timing_b_dual;

    assign hit_oadj = (i_addr == adc_trim_pkg::OFF_OFFSET_A_LO) ||
                      (i_addr == adc_trim_pkg::OFF_OFFSET_A_HI);

    always_comb begin
        state_nxt = state_r;
        state_nxt.rdata = adc_trim_pkg::RDATA_IDLE;

        // Factory trim copied in once after reset
        if (fuse_load) begin
            state_nxt.tadj = factory_tadj;
            state_nxt.oadj = {adc_trim_pkg::OADJ_RSVD_RESET, i_factory_offset_a_input_a};
        end
        state_nxt.loaded = fuse_done;

        // Software write wins over a same-cycle factory load
        if (i_wr) begin
            for (int i = 0; i < TADJ_N; i++) begin
                if (i_addr == 12'(adc_trim_pkg::OFF_TIMING_B_SINGLE_BG + 12'(i))) begin
                    state_nxt.tadj[i] = i_wdata;
                end
            end
            if (i_addr == adc_trim_pkg::OFF_OFFSET_A_LO) begin
                state_nxt.oadj[7:0] = i_wdata;
            end
            if (i_addr == adc_trim_pkg::OFF_OFFSET_A_HI) begin
                state_nxt.oadj[15:8] = i_wdata;
            end
        end

        // Read data stands for one cycle, unmapped reads return zero
        if (i_rd) begin
            for (int i = 0; i < TADJ_N; i++) begin
                if (i_addr == 12'(adc_trim_pkg::OFF_TIMING_B_SINGLE_BG + 12'(i))) begin
                    state_nxt.rdata = state_r.tadj[i];
                end
            end
            if (i_addr == adc_trim_pkg::OFF_OFFSET_A_LO) begin
                state_nxt.rdata = state_r.oadj[7:0];
            end
            if (i_addr == adc_trim_pkg::OFF_OFFSET_A_HI) begin
                state_nxt.rdata = state_r.oadj[15:8];
            end
        end

        // Flag software accesses made while calibration owns the offset
        state_nxt.wr_hazard = i_wr && hit_oadj &&
            (i_foreground_calibration_busy ||
             (i_background_calibration_enable && i_background_offset_calibration_enable));
        state_nxt.rd_hazard = i_rd && hit_oadj &&
            ((i_offset_calibration_enable && !i_background_offset_calibration_enable &&
              !i_foreground_calibration_done) ||
             (i_background_calibration_enable && i_background_offset_calibration_enable &&
              !i_calibration_stopped_flag));

        // Core controls
        state_nxt.core_timing = sel_timing;
        state_nxt.core_valid = sel_valid;
        state_nxt.core_a_apply = i_core_a_samples_input_a;
        state_nxt.core_a_offset = i_core_a_samples_input_a ?
            state_r.oadj[adc_trim_pkg::OADJ_VALUE_W-1:0] : 12'h000;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= '{tadj: {TADJ_N{adc_trim_pkg::TADJ_RESET}},
                         oadj: adc_trim_pkg::OADJ_RESET,
                         rdata: adc_trim_pkg::RDATA_IDLE,
                         default: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_rdata = state_r.rdata;
    assign o_core_a_timing = state_r.core_timing[adc_trim_pkg::CORE_A];
    assign o_core_b_timing = state_r.core_timing[adc_trim_pkg::CORE_B];
    assign o_core_c_timing = state_r.core_timing[adc_trim_pkg::CORE_C];
    assign o_core_timing_valid = state_r.core_valid;
    assign o_core_a_offset = state_r.core_a_offset;
    assign o_core_a_offset_apply = state_r.core_a_apply;
    assign o_trim_loaded = state_r.loaded;
    assign o_offset_write_hazard = state_r.wr_hazard;
    assign o_offset_read_hazard = state_r.rd_hazard;

    default clocking cb @(posedge i_clock);
    endclocking

    default disable iff (!i_rst_n);

    a_dual_core_a: assert property (
        i_dual_channel_mode |=> o_core_a_timing == $past(state_r.tadj[adc_trim_pkg::IDX_A_DUAL]))
        else $error("core A timing not taken from dual A register");

    a_core_c_phase: assert property (
        i_dual_channel_mode && i_background_phase
        |=> o_core_c_timing == $past(state_r.tadj[adc_trim_pkg::IDX_C_FOR_B_DUAL]))
        else $error("core C timing wrong for phase standing in for B");

    a_tadj_readback: assert property (
        i_wr && i_addr == adc_trim_pkg::OFF_TIMING_B_DUAL
        ##1 i_rd && i_addr == adc_trim_pkg::OFF_TIMING_B_DUAL
        |=> o_rdata == $past(i_wdata, 2))
        else $error("timing register did not read back written value");

    a_factory_load: assert property (
        fuse_load && !i_wr |=> state_r.tadj[adc_trim_pkg::IDX_A_DUAL] == $past(i_factory_timing_a_dual)
        ##1 o_trim_loaded)
        else $error("factory trim not loaded");

    a_dual_c_for_a: assert property (
        i_dual_channel_mode && !i_background_phase
        |=> o_core_c_timing == $past(state_r.tadj[adc_trim_pkg::IDX_C_FOR_A_DUAL])
            && o_core_timing_valid == 3'h7)
        else $error("core C timing wrong for phase standing in for A");

    a_single_core_b: assert property (
        !i_dual_channel_mode && !i_background_phase
        |=> o_core_b_timing == $past(state_r.tadj[adc_trim_pkg::IDX_B_SINGLE_BG])
            && o_core_timing_valid == 3'h2)
        else $error("single-channel core B background timing wrong");

    a_offset_high_read: assert property (
        i_rd && i_addr == adc_trim_pkg::OFF_OFFSET_A_HI
        |=> o_rdata == $past(state_r.oadj[15:8]) ##1 o_rdata == adc_trim_pkg::RDATA_IDLE || $past(i_rd))
        else $error("offset high byte read wrong");

    a_offset_input_a: assert property (
        i_core_a_samples_input_a |=> o_core_a_offset_apply
            && o_core_a_offset == $past(state_r.oadj[11:0]))
        else $error("offset not applied while sampling input A");

    a_offset_off: assert property (
        !i_core_a_samples_input_a |=> !o_core_a_offset_apply && o_core_a_offset == 12'h000)
        else $error("offset applied off input A");

    a_reserved_load: assert property (
        $rose(o_trim_loaded) |-> state_r.oadj[15:12] == 4'h0 || $past(i_wr) || $past(i_wr, 2))
        else $error("reserved offset bits not cleared by load");

    a_dual_core_b: assert property (
        i_dual_channel_mode |=> o_core_b_timing == $past(state_r.tadj[adc_trim_pkg::IDX_B_DUAL]))
        else $error("core B timing not taken from dual B register");

    a_single_idle: assert property (
        !i_dual_channel_mode && i_background_phase
        |=> o_core_timing_valid == 3'h0 && o_core_b_timing == 8'h00)
        else $error("single-channel core B driven outside phase 0");

    a_single_others: assert property (
        !i_dual_channel_mode |=> o_core_a_timing == 8'h00 && o_core_c_timing == 8'h00)
        else $error("cores A or C driven in single-channel mode");

    a_tadj_write: assert property (
        i_wr && i_addr == adc_trim_pkg::OFF_TIMING_A_DUAL
        |=> state_r.tadj[adc_trim_pkg::IDX_A_DUAL] == $past(i_wdata))
        else $error("timing register write lost");

    a_rdata_idle: assert property (
        !i_rd |=> o_rdata == adc_trim_pkg::RDATA_IDLE)
        else $error("read data not idle without a read");

    a_loaded_holds: assert property (
        o_trim_loaded |=> o_trim_loaded)
        else $error("trim loaded flag dropped");

    a_offset_low_write: assert property (
        i_wr && i_addr == adc_trim_pkg::OFF_OFFSET_A_LO |=> state_r.oadj[7:0] == $past(i_wdata))
        else $error("offset low byte write lost");

    a_offset_low_read: assert property (
        i_rd && i_addr == adc_trim_pkg::OFF_OFFSET_A_LO |=> o_rdata == $past(state_r.oadj[7:0]))
        else $error("offset low byte read wrong");

    a_reserved_write: assert property (
        i_wr && i_addr == adc_trim_pkg::OFF_OFFSET_A_HI |=> state_r.oadj[15:8] == $past(i_wdata))
        else $error("reserved offset bits not writable");

    a_write_hazard: assert property (
        i_wr && hit_oadj && i_foreground_calibration_busy |=> o_offset_write_hazard)
        else $error("offset write during foreground calibration not flagged");

    a_write_hazard_bg: assert property (
        i_wr && hit_oadj && i_background_calibration_enable && i_background_offset_calibration_enable
        |=> o_offset_write_hazard)
        else $error("offset write under background offset calibration not flagged");

    a_read_hazard_fg: assert property (
        i_rd && hit_oadj && i_offset_calibration_enable && !i_background_offset_calibration_enable
        && !i_foreground_calibration_done |=> o_offset_read_hazard)
        else $error("offset read before foreground done not flagged");

    a_read_hazard: assert property (
        i_rd && hit_oadj && i_background_calibration_enable && i_background_offset_calibration_enable
        && !i_calibration_stopped_flag |=> o_offset_read_hazard)
        else $error("offset read while calibration runs not flagged");

    a_hazard_quiet: assert property (
        !i_wr && !i_rd |=> !o_offset_write_hazard && !o_offset_read_hazard)
        else $error("hazard flagged without an access");

    c_write_hazard: cover property (o_offset_write_hazard);
    c_read_hazard: cover property (o_offset_read_hazard);
    c_phase_switch: cover property (i_dual_channel_mode && !i_background_phase ##1 i_background_phase);
    c_offset_rw: cover property (i_wr && i_addr == adc_trim_pkg::OFF_OFFSET_A_LO ##1 i_rd);
    c_single_phase0: cover property (!i_dual_channel_mode && !i_background_phase ##1 o_core_timing_valid == 3'h2);

endmodule

`default_nettype wire

// File: adc_core_trim_register_bank_tb_top.sv
`default_nettype none

module adc_core_trim_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] fac [5] = '{8'h3c, 8'h5a, 8'ha5, 8'hc3, 8'h96};
    logic [11:0] fac_off = 12'h9e7;
    logic dual = 1'b0;
    logic phase = 1'b0;
    logic on_a = 1'b0;
    logic [5:0] cal = 6'h00;
    logic [7:0] o_rdata, ta, tb, tc;
    logic [2:0] tv;
    logic [11:0] o_core_a_offset;
    logic o_core_a_offset_apply, o_trim_loaded, whaz, rhaz;
    logic [7:0] shadow [5];
    logic [15:0] oadj;
    int num_errors = 0;
    int total_checks = 0;

    adc_core_trim_register_bank u_adc_core_trim_register_bank (
        .i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_factory_timing_b_single_bg(fac[0]), .i_factory_timing_a_dual(fac[1]),
        .i_factory_timing_c_for_a_dual(fac[2]), .i_factory_timing_c_for_b_dual(fac[3]),
        .i_factory_timing_b_dual(fac[4]), .i_factory_offset_a_input_a(fac_off),
        .i_dual_channel_mode(dual), .i_background_phase(phase), .i_core_a_samples_input_a(on_a),
        .i_foreground_calibration_busy(cal[5]), .i_foreground_calibration_done(cal[4]),
        .i_offset_calibration_enable(cal[3]), .i_background_calibration_enable(cal[2]),
        .i_background_offset_calibration_enable(cal[1]), .i_calibration_stopped_flag(cal[0]),
        .o_core_a_timing(ta), .o_core_b_timing(tb), .o_core_c_timing(tc), .o_core_timing_valid(tv),
        .o_core_a_offset(o_core_a_offset), .o_core_a_offset_apply(o_core_a_offset_apply),
        .o_trim_loaded(o_trim_loaded), .o_offset_write_hazard(whaz), .o_offset_read_hazard(rhaz)
    );

    always #10 i_clock = ~i_clock;

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
    endtask

    function automatic logic [7:0] exp_rd(input logic [11:0] a);
        if (a >= 12'h085 && a <= 12'h089) return shadow[a - 12'h085];
        if (a == 12'h08a) return oadj[7:0];
        if (a == 12'h08b) return oadj[15:8];
        return 8'h00;
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic hz);
        cyc(1'b1, 1'b0, a, d);
        i_wr <= 1'b0;
        if (a >= 12'h085 && a <= 12'h089) shadow[a - 12'h085] = d;
        if (a == 12'h08a) oadj[7:0] = d;
        if (a == 12'h08b) oadj[15:8] = d;
        @(negedge i_clock);
        chk_flag(whaz, hz);
        @(posedge i_clock);
    endtask

    task automatic rd(input logic [11:0] a, input logic hz);
        cyc(1'b0, 1'b1, a, 8'h00);
        i_rd <= 1'b0;
        @(negedge i_clock);
        chk_byte(o_rdata, exp_rd(a));
        chk_flag(rhaz, hz);
        @(posedge i_clock);
    endtask

    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 20 && o_trim_loaded !== 1'b1; k++) @(negedge i_clock);
        chk_flag(o_trim_loaded, 1'b1);
        @(posedge i_clock);
        foreach (shadow[i]) shadow[i] = fac[i];
        oadj = {4'h0, fac_off};
    endtask

    task automatic test_reset_values();
        for (int i = 0; i < 7; i++) rd(12'h085 + 12'(i), 1'b0);
        $display("test reset_values done");
    endtask

    task automatic test_write_read();
        for (int i = 0; i < 7; i++) wr(12'h085 + 12'(i), 8'(i * 17) ^ 8'h0f, 1'b0);
        wr(12'h08b, 8'hf5, 1'b0);
        wr(12'h084, 8'h44, 1'b0);
        wr(12'h08c, 8'h44, 1'b0);
        for (int i = 0; i < 9; i++) rd(12'h084 + 12'(i), 1'b0);
        cyc(1'b1, 1'b0, 12'h089, 8'h77);
        cyc(1'b0, 1'b1, 12'h089, 8'h00);
        i_rd <= 1'b0;
        shadow[4] = 8'h77;
        @(negedge i_clock);
        chk_byte(o_rdata, 8'h77);
        @(negedge i_clock);
        chk_byte(o_rdata, 8'h00);
        @(posedge i_clock);
        cyc(1'b1, 1'b0, 12'h08a, 8'hc4);
        cyc(1'b0, 1'b1, 12'h08a, 8'h00);
        i_rd <= 1'b0;
        oadj[7:0] = 8'hc4;
        @(negedge i_clock);
        chk_byte(o_rdata, 8'hc4);
        @(posedge i_clock);
        $display("test write_read done");
    endtask

    task automatic test_core_select();
        logic [7:0] ea, eb, ec;
        logic [2:0] ev;
        for (int m = 0; m < 4; m++) begin
            dual <= m[1];
            phase <= m[0];
            @(posedge i_clock);
            @(negedge i_clock);
            ev = m[1] ? 3'h7 : (m[0] ? 3'h0 : 3'h2);
            ea = m[1] ? shadow[1] : 8'h00;
            eb = m[1] ? shadow[4] : (m[0] ? 8'h00 : shadow[0]);
            ec = m[1] ? (m[0] ? shadow[3] : shadow[2]) : 8'h00;
            chk_word({9'h000, tv}, {9'h000, ev});
            chk_byte(ta, ea);
            chk_byte(tb, eb);
            chk_byte(tc, ec);
            @(posedge i_clock);
        end
        $display("test core_select done");
    endtask

    task automatic test_offset_apply();
        for (int s = 1; s >= 0; s--) begin
            on_a <= s[0];
            @(posedge i_clock);
            @(negedge i_clock);
            chk_word(o_core_a_offset, s[0] ? oadj[11:0] : 12'h000);
            chk_flag(o_core_a_offset_apply, s[0]);
            @(posedge i_clock);
        end
        $display("test offset_apply done");
    endtask

    task automatic test_hazards();
        logic [5:0] combos [6] = '{6'b100000, 6'b001000, 6'b011000, 6'b000110, 6'b000111, 6'b000000};
        logic ew, er;
        foreach (combos[i]) begin
            cal <= combos[i];
            @(posedge i_clock);
            ew = combos[i][5] | (combos[i][2] & combos[i][1]);
            er = (combos[i][3] & ~combos[i][1] & ~combos[i][4]) | (combos[i][2] & combos[i][1] & ~combos[i][0]);
            wr(12'h08a, 8'h30 + 8'(i), ew);
            wr(12'h086, 8'h60 + 8'(i), 1'b0);
            rd(12'h08a, er);
        end
        $display("test hazards done");
    endtask

    task automatic test_second_reset();
        do_reset();
        rd(12'h086, 1'b0);
        rd(12'h08b, 1'b0);
        $display("test second_reset done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clock);
        num_errors++;
        end_of_test();
    end

    initial begin
        do_reset();
        test_reset_values();
        test_write_read();
        test_core_select();
        test_offset_apply();
        test_hazards();
        test_second_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
